// [fwp_bp_decode.sv]
// Purpose: constants of the flash write-protect block and its area-size protect decoder
// Assumes: 16 MB array of 256 sectors, 16 subsectors each
// Notes: package and leaf decoder share this file

package fwp_pkg;
   localparam int ADDR_W = 24;
   localparam int SECT_W = 8;
   localparam int SUBS_W = 12;
   localparam int NUM_SECT = 256;
   localparam int SECT_LSB = 16;
   localparam int SUBS_LSB = 12;
   // apb byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_LOCK = 8'h0c;
   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ARG_LSB = 4;
   localparam int CMD_CNT_LSB = 16;
   localparam int ARG_WLOCK = 0;
   localparam int ARG_LDOWN = 1;
   localparam int ARG_TB = 4;
   // status word fields
   localparam int ST_WEL = 0;
   localparam int ST_PWR = 1;
   localparam int ST_TB = 2;
   localparam int ST_CODE_LSB = 3;
   localparam int ST_REJ_LSB = 8;
   localparam int ST_OK = 11;
   // lock word fields
   localparam int LK_WLOCK = 0;
   localparam int LK_LDOWN = 1;
   localparam int LK_BPROT = 2;
   localparam int LK_SUBS_LSB = 4;
   localparam int LK_SECT_LSB = 16;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CODE_ALL = 9;
   localparam logic [9:0] ALL_SECT = 10'h100;
   typedef enum logic [3:0] {OP_NOP, OP_WREN, OP_WRDI, OP_PROG, OP_SSE, OP_SE, OP_CE, OP_LOCKW, OP_WRSR} fwp_op_e;
   typedef enum logic [2:0] {REJ_NONE, REJ_FRACT, REJ_PWRUP, REJ_NOWEL, REJ_PROT, REJ_LDOWN} fwp_rej_e;
endpackage

`timescale 1ns/10ps

module fwp_bp_decode
   import fwp_pkg::*;
(
   input wire logic tb_sel,
   input wire logic [3:0] area_code,
   input wire logic [SECT_W-1:0] sector,
   output logic prot
);

   logic [9:0] count;
   logic [9:0] top_sum;

   always_comb
   begin
      if (area_code == 4'h0)
         count = 10'h000;
      else if (int'(area_code) >= CODE_ALL)
         count = ALL_SECT;
      else
         count = 10'h001 << (area_code - 4'h1);
      top_sum = {2'b00, sector} + count;
      if (tb_sel)
         prot = {2'b00, sector} < count;
      else
         prot = top_sum >= ALL_SECT;
   end

endmodule

// [fwp_top.sv]
// Purpose: write-protect and address decode of a serial nor flash, reached over apb
// Assumes: command words arrive already framed, with their clock pulse count
// Notes: accepted program/erase commands leave as a one-cycle exec pulse
//
// The address map and register access over APB were chosen for this implementation.

`timescale 1ns/10ps

module fwp_top
   import fwp_pkg::*;
#(
   parameter int PWRUP_TIME_NS = 150000,
   parameter int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic exec_valid,
   output logic [3:0] exec_op,
   output logic [ADDR_W-1:0] exec_addr
);

   localparam int CNT_W = $clog2(PWRUP_CYCLES + 1);

   generate
      if (PWRUP_CYCLES < 1)
      begin : g_bad
         $error("power-up count must be at least one cycle");
      end
   endgenerate

   function automatic logic is_modify(input fwp_op_e op);
      is_modify = (op == OP_PROG) || (op == OP_SSE) || (op == OP_SE) || (op == OP_CE) || (op == OP_LOCKW)
         || (op == OP_WRSR);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [CNT_W-1:0] pwr_cnt, next_pwr_cnt;
   logic powered, next_powered;
   logic wel, next_wel;
   logic tb_sel, next_tb_sel;
   logic [3:0] area_code, next_area_code;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [NUM_SECT-1:0] wlock, next_wlock;
   logic [NUM_SECT-1:0] ldown, next_ldown;
   logic [2:0] last_rej, next_last_rej;
   logic last_ok, next_last_ok;
   logic next_pready, next_pslverr, next_exec_valid;
   logic [31:0] next_prdata;
   logic [3:0] next_exec_op;
   logic [ADDR_W-1:0] next_exec_addr;

   logic [SECT_W-1:0] sector;
   logic [SUBS_W-1:0] subsector;
   logic bp_prot, any_prot, sect_prot, wr_done, rd_done, cmd_wr;
   logic op_known;
   logic [15:0] pulse_cnt;
   logic [7:0] arg;
   fwp_op_e op;
   fwp_rej_e rej;

   ////////////////////////////////////////////////////////////////////////////
   // address decode and protection lookup

   assign sector = addr[SECT_LSB +: SECT_W];
   assign subsector = addr[SUBS_LSB +: SUBS_W];

   fwp_bp_decode u_bp (
      .tb_sel(tb_sel),
      .area_code(area_code),
      .sector(sector),
      .prot(bp_prot)
   );

   // a nonzero area code always covers at least one sector
   assign any_prot = (|wlock) || (area_code != 4'h0);
   assign sect_prot = wlock[sector] || bp_prot;

   assign wr_done = psel && penable && pready && pwrite;
   assign rd_done = psel && penable && !pready && !pwrite;
   assign cmd_wr = wr_done && (paddr[7:0] == OFS_CMD) && (paddr[31:8] == 24'h000000);
   assign op = fwp_op_e'(pwdata[CMD_OP_LSB +: 4]);
   assign arg = pwdata[CMD_ARG_LSB +: 8];
   assign pulse_cnt = pwdata[CMD_CNT_LSB +: 16];
   // codes past the last defined op are dropped without touching the status word
   assign op_known = (pwdata[CMD_OP_LSB +: 4] <= 4'(OP_WRSR));

   ////////////////////////////////////////////////////////////////////////////
   // power-up timer

   always_comb
   begin
      next_pwr_cnt = pwr_cnt;
      next_powered = powered;
      if (!powered)
      begin
         next_pwr_cnt = pwr_cnt + CNT_W'(1);
         next_powered = (pwr_cnt == CNT_W'(PWRUP_CYCLES - 1));
      end
   end

   // counter freezes once powered, so it never wraps back into blocking
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_cnt <= '0;
         powered <= 1'b0;
      end
      else
      begin
         pwr_cnt <= next_pwr_cnt;
         powered <= next_powered;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command check
   // only the first failing check is reported in the status word

   always_comb
   begin
      rej = REJ_NONE;
      if ((pulse_cnt[2:0] != 3'h0) || (pulse_cnt == 16'h0000))
         rej = REJ_FRACT;
      else if (!powered)
         rej = REJ_PWRUP;
      else if (is_modify(op) && !wel)
         rej = REJ_NOWEL;
      else if (op == OP_LOCKW && ldown[sector])
         rej = REJ_LDOWN;
      else if ((op == OP_PROG || op == OP_SSE || op == OP_SE) && sect_prot)
         rej = REJ_PROT;
      else if (op == OP_CE && any_prot)
         rej = REJ_PROT;
   end

   always_comb
   begin
      next_wel = wel;
      next_tb_sel = tb_sel;
      next_area_code = area_code;
      next_wlock = wlock;
      next_ldown = ldown;
      next_last_rej = last_rej;
      next_last_ok = last_ok;
      next_exec_valid = 1'b0;
      next_exec_op = exec_op;
      next_exec_addr = exec_addr;
      next_addr = addr;
      if (wr_done && (paddr[7:0] == OFS_ADDR) && (paddr[31:8] == 24'h000000))
         next_addr = pwdata[ADDR_W-1:0];
      if (cmd_wr && op_known && op != OP_NOP)
      begin
         next_last_rej = rej;
         next_last_ok = (rej == REJ_NONE);
         // discarded fragments leave the latch alone; any whole modify attempt clears it
         if (rej != REJ_FRACT && is_modify(op))
            next_wel = 1'b0;
         if (rej == REJ_NONE)
         begin
            unique case (op)
               OP_WREN:
                  next_wel = 1'b1;
               OP_WRDI:
                  next_wel = 1'b0;
               OP_WRSR:
               begin
                  next_area_code = arg[3:0];
                  next_tb_sel = arg[ARG_TB];
               end
               OP_LOCKW:
               begin
                  next_wlock[sector] = arg[ARG_WLOCK];
                  next_ldown[sector] = arg[ARG_LDOWN];
               end
               OP_PROG, OP_SSE, OP_SE, OP_CE:
               begin
                  next_exec_valid = 1'b1;
                  next_exec_op = op;
                  next_exec_addr = addr;
               end
               default:
                  next_exec_valid = 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state on every access

   always_comb
   begin
      next_pready = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata = 32'h00000000;
      if (next_pready)
      begin
         next_pslverr = (paddr[31:8] != 24'h000000) || (paddr[7:0] > OFS_LOCK) || (paddr[1:0] != 2'b00);
         if (rd_done)
         begin
            unique case (paddr[7:0])
               OFS_ADDR:
                  next_prdata[ADDR_W-1:0] = addr;
               OFS_STAT:
               begin
                  next_prdata[ST_WEL] = wel;
                  next_prdata[ST_PWR] = powered;
                  next_prdata[ST_TB] = tb_sel;
                  next_prdata[ST_CODE_LSB +: 4] = area_code;
                  next_prdata[ST_REJ_LSB +: 3] = last_rej;
                  next_prdata[ST_OK] = last_ok;
               end
               OFS_LOCK:
               begin
                  next_prdata[LK_WLOCK] = wlock[sector];
                  next_prdata[LK_LDOWN] = ldown[sector];
                  next_prdata[LK_BPROT] = bp_prot;
                  next_prdata[LK_SUBS_LSB +: SUBS_W] = subsector;
                  next_prdata[LK_SECT_LSB +: SECT_W] = sector;
               end
               default:
                  next_prdata = 32'h00000000;
            endcase
         end
      end
   end

   // bus answer registers, apart from the command state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wel <= 1'b0;
         tb_sel <= 1'b0;
         area_code <= 4'h0;
         addr <= '0;
         wlock <= '1;
         ldown <= '0;
         last_rej <= REJ_NONE;
         last_ok <= 1'b0;
         exec_valid <= 1'b0;
         exec_op <= 4'h0;
         exec_addr <= '0;
      end
      else
      begin
         wel <= next_wel;
         tb_sel <= next_tb_sel;
         area_code <= next_area_code;
         addr <= next_addr;
         wlock <= next_wlock;
         ldown <= next_ldown;
         last_rej <= next_last_rej;
         last_ok <= next_last_ok;
         exec_valid <= next_exec_valid;
         exec_op <= next_exec_op;
         exec_addr <= next_exec_addr;
      end
   end

endmodule

// [fwp_props.sv]
// Purpose: port checker for fwp_top
// Assumes: cmd word at 0x00, address at 0x04
// Notes: helper logic mirrors the latch, the last words and a cycle count since reset
`timescale 1ns/10ps
module fwp_props
   import fwp_pkg::*;
#(
   parameter int PWRUP_CYCLES = 10
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic exec_valid,
   input wire logic [3:0] exec_op,
   input wire logic [ADDR_W-1:0] exec_addr
);
   logic tk;
   logic ct;
   logic wel;
   logic wel_at;
   logic [31:0] cmd_q;
   logic [23:0] addr_q;
   int up;
   assign tk = psel && penable && pready && pwrite;
   assign ct = tk && paddr == 32'h0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         up <= 0;
         wel <= 1'b0;
         wel_at <= 1'b0;
         cmd_q <= 32'h0;
         addr_q <= 24'h0;
      end
      else
      begin
         up <= up + 1;
         if (ct)
            cmd_q <= pwdata;
         if (ct)
            wel_at <= wel;
         // fractional words leave the latch alone
         if (ct && pwdata[18:16] == 3'h0 && pwdata[31:16] != 16'h0 && pwdata[3:0] inside {[4'h1:4'h8]})
            wel <= pwdata[3:0] == 4'h1 && up >= PWRUP_CYCLES;
         if (tk && paddr == 32'h4)
            addr_q <= pwdata[23:0];
      end
   ////////////////////////////////////////////////////////////
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready too long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_rd0; !pready |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("prdata outside answer");
   property p_frac; exec_valid |-> cmd_q[18:16] == 3'h0 && cmd_q[31:16] != 16'h0; endproperty
   a_frac: assert property (p_frac) else $error("fractional command ran");
   property p_wel; exec_valid |-> wel_at; endproperty
   a_wel: assert property (p_wel) else $error("exec without latch");
   property p_pwr; exec_valid |-> up >= PWRUP_CYCLES; endproperty
   a_pwr: assert property (p_pwr) else $error("exec before power-up");
   property p_op; exec_valid |-> exec_op == cmd_q[3:0] && exec_op inside {[4'h3:4'h6]}; endproperty
   a_op: assert property (p_op) else $error("wrong exec op");
   property p_addr; exec_valid |-> exec_addr == addr_q; endproperty
   a_addr: assert property (p_addr) else $error("wrong exec address");
   property p_lat; exec_valid |-> $past(ct, 1) || $past(ct, 2); endproperty
   a_lat: assert property (p_lat) else $error("exec without command");
endmodule
bind fwp_top fwp_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_props (.*);

// [fwp_host.sv]
// Purpose: apb command source standing in for the flash host
// Assumes: one transfer at a time
// Notes: waits on pready with no cycle count of its own
`timescale 1ns/10ps
module fwp_host
   import fwp_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [31:0] dr;
   logic de;
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cmd(input logic [3:0] op, input logic [7:0] arg, input logic [15:0] cnt);
      xfer(1'b1, 32'(OFS_CMD), {cnt, 4'h0, arg, op}, dr, de);
   endtask
   task mod(input logic [3:0] op, input logic [7:0] arg);
      cmd(OP_WREN, 8'h0, 16'h8);
      cmd(op, arg, 16'h8);
   endtask
endmodule

// [flash_write_protect_logic_test.sv]
// Purpose: register-level test of fwp_top
// Assumes: power-up time shortened to 80 ns
// Notes: stat reads compare the reject code; the latch is checked after some of them
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module flash_write_protect_logic_test
   import fwp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_valid, e;
   logic [31:0] paddr, pwdata, prdata, r;
   logic [3:0] exec_op;
   logic [ADDR_W-1:0] exec_addr;
   logic [7:0] s;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int execs = 0;
   fwp_top #(.PWRUP_TIME_NS(80)) uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .exec_valid(exec_valid),
      .exec_op(exec_op),
      .exec_addr(exec_addr)
   );
   fwp_host host (
      .pclk(pclk),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );
   function automatic int size(logic [3:0] c);
      return (c == 0) ? 0 : (c > 8) ? 256 : 1 << (c - 1);
   endfunction
   task results;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task st(input logic [2:0] rj);
      host.xfer(1'b0, 32'(OFS_STAT), 32'h0, r, e);
      `CHK("reject", rj, r[10:8])
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (exec_valid === 1'b1)
         execs++;
      if (cyc == 20000)
      begin
         num_errors++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      host.xfer(1'b1, 32'(OFS_ADDR), 32'h123456, r, e);
      host.cmd(OP_PROG, 8'h0, 16'h8);
      st(REJ_PWRUP);
      repeat (12) @(posedge pclk);
      host.xfer(1'b0, 32'(OFS_LOCK), 32'h0, r, e);
      `CHK("lock", 32'h00121231, r)
      host.mod(OP_PROG, 8'h0);
      st(REJ_PROT);
      host.cmd(OP_WREN, 8'h0, 16'h7);
      st(REJ_FRACT);
      `CHK("wel", 1'b0, r[0])
      host.cmd(OP_PROG, 8'h0, 16'h8);
      st(REJ_NOWEL);
      host.mod(OP_LOCKW, 8'h0);
      host.mod(OP_PROG, 8'h0);
      @(posedge pclk);
      `CHK("exec", 1'b1, exec_valid)
      @(posedge pclk);
      `CHK("exec end", 1'b0, exec_valid)
      `CHK("op", OP_PROG, exec_op)
      `CHK("addr", 24'h123456, exec_addr)
      host.mod(OP_LOCKW, 8'h3);
      host.mod(OP_LOCKW, 8'h0);
      st(REJ_LDOWN);
      host.xfer(1'b0, 32'(OFS_LOCK), 32'h0, r, e);
      `CHK("ldown", 2'h3, r[1:0])
      $display("lock test done");
      for (int t = 0; t < 2; t++)
         for (int c = 0; c < 16; c++)
         begin
            host.mod(OP_WRSR, 8'(t * 16 + c));
            // for codes 1 to 8, k=1 is the protected sector at the area edge, k=0 the open sector next to it; code 0 leaves both open, codes 9 to 15 protect both
            for (int k = 0; k < 2; k++)
            begin
               s = 8'(t ? size(4'(c)) - k : 255 - size(4'(c)) + k);
               host.xfer(1'b1, 32'(OFS_ADDR), {8'h0, s, 16'h0}, r, e);
               host.xfer(1'b0, 32'(OFS_LOCK), 32'h0, r, e);
               `CHK("area", t ? (s < size(4'(c))) : (s >= 256 - size(4'(c))), r[2])
            end
         end
      $display("area test done");
      host.mod(OP_CE, 8'h0);
      st(REJ_PROT);
      host.xfer(1'b0, 32'h10, 32'h0, r, e);
      `CHK("slverr", 1'b1, e)
      host.xfer(1'b1, 32'(OFS_ADDR), 32'h400000, r, e);
      host.mod(OP_LOCKW, 8'h0);
      host.mod(OP_SE, 8'h0);
      st(REJ_PROT);
      host.mod(OP_WRSR, 8'h00);
      host.mod(OP_SE, 8'h0);
      st(REJ_NONE);
      `CHK("se", OP_SE, exec_op)
      host.mod(OP_SSE, 8'h0);
      st(REJ_NONE);
      `CHK("sse", OP_SSE, exec_op)
      `CHK("sse addr", 24'h400000, exec_addr)
      host.cmd(OP_WREN, 8'h0, 16'h8);
      host.xfer(1'b0, 32'(OFS_STAT), 32'h0, r, e);
      `CHK("wel on", 1'b1, r[0])
      host.cmd(OP_WRDI, 8'h0, 16'h8);
      host.cmd(OP_SSE, 8'h0, 16'h8);
      st(REJ_NOWEL);
      `CHK("wel off", 1'b0, r[0])
      host.cmd(OP_WREN, 8'h0, 16'h8);
      host.cmd(OP_SSE, 8'h0, 16'hc);
      st(REJ_FRACT);
      `CHK("wel kept", 1'b1, r[0])
      host.cmd(4'hf, 8'h0, 16'h8);
      st(REJ_FRACT);
      $display("erase test done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      host.xfer(1'b1, 32'(OFS_ADDR), 32'h120000, r, e);
      host.cmd(OP_WREN, 8'h0, 16'h8);
      st(REJ_PWRUP);
      `CHK("wel reset", 1'b0, r[0])
      repeat (12) @(posedge pclk);
      host.xfer(1'b0, 32'(OFS_LOCK), 32'h0, r, e);
      `CHK("relock", 32'h00121201, r)
      `CHK("execs", 3, execs)
      $display("reset test done");
      results();
   end
endmodule
